// File: logic/pecd_map.svh
`ifndef PECD_MAP_SVH
`define PECD_MAP_SVH

// register indices; byte address on the bus is four times the index
`define PECD_IDX_W          12
`define PECD_ADDR_W         16
`define PECD_IDX_A_FLAGS    12'hF05
`define PECD_IDX_A_FALL     12'hF06
`define PECD_IDX_A_RISE     12'hF07
`define PECD_IDX_B_FLAGS    12'hF0D
`define PECD_IDX_B_FALL     12'hF0E
`define PECD_IDX_B_RISE     12'hF0F
`define PECD_IDX_C_FLAGS    12'hF15
`define PECD_IDX_C_FALL     12'hF16
`define PECD_IDX_C_RISE     12'hF17
`define PECD_IDX_E_FLAGS    12'hF22
`define PECD_IDX_E_FALL     12'hF23
`define PECD_IDX_E_RISE     12'hF24
`define PECD_IDX_CTRL       12'hF30
`define PECD_IDX_STATUS     12'hF31
`define PECD_IDX_INT_STAT   12'hF32
`define PECD_IDX_INT_MASK   12'hF33

// control register fields
`define PECD_CTRL_CIE       0
`define PECD_CTRL_RPE       1
`define PECD_CTRL_LVP       2
// status register fields
`define PECD_STAT_SUMMARY   0
`define PECD_STAT_E_AVAIL   1

// port E carries only pin 3
`define PECD_E_BIT          3
`define PECD_E_MASK         8'h08
`define PECD_RST_BYTE       8'h00

`define PECD_RESP_OKAY      2'h0
`define PECD_RESP_DECERR    2'h3

`endif

// File: logic/pecd_pkg.sv
`default_nettype none
package pecd_pkg;

  typedef struct packed {
    logic [7:0] s1;
    logic [7:0] s2;
    logic [7:0] prev;
  } pecd_sync_t;

  typedef enum logic [1:0] {
    PECD_K_FLAGS,
    PECD_K_FALL,
    PECD_K_RISE
  } pecd_kind_t;

  typedef struct packed {
    logic [3:0][7:0] rise_en;
    logic [3:0][7:0] fall_en;
    logic [3:0][7:0] flags;
    logic            cie;
    logic            rpe;
    logic            low_voltage_program_setting;
    logic [3:0]      int_status;
    logic [3:0]      int_mask;
    logic            irq;
  } pecd_top_st_t;

  typedef struct packed {
    logic        aw_held;
    logic [11:0] aw_idx;
    logic        w_held;
    logic [7:0]  wdata;
    logic        wlane0;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } pecd_axil_st_t;

endpackage : pecd_pkg
`default_nettype wire

// File: logic/pecd_if.sv
`default_nettype none
interface pecd_if;
  logic        wr_en;
  logic [11:0] wr_idx;
  logic [7:0]  wr_data;
  logic        wr_hit;
  logic [11:0] rd_idx;
  logic [7:0]  rd_data;
  logic        rd_hit;

  modport bus_side (output wr_en, output wr_idx, output wr_data, output rd_idx,
                    input wr_hit, input rd_data, input rd_hit);
  modport reg_side (input wr_en, input wr_idx, input wr_data, input rd_idx,
                    output wr_hit, output rd_data, output rd_hit);
endinterface : pecd_if
`default_nettype wire

// File: logic/pecd_edge.sv
`include "pecd_map.svh"
`default_nettype none
module pecd_edge
  import pecd_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic [7:0] pins,
  input  wire logic [7:0] en_rise,
  input  wire logic [7:0] en_fall,
  output logic      [7:0] hit
);

  pecd_sync_t s_reg;
  pecd_sync_t s_next;
  logic [7:0] rise;
  logic [7:0] fall;

  ////////////////////////////////////////////////////////////////////////////
  always_comb
  begin
    s_next      = s_reg;
    s_next.s1   = pins;
    s_next.s2   = s_reg.s1;
    s_next.prev = s_reg.s2;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      s_reg <= '0;
    end
    else
    begin
      s_reg <= s_next;
    end
  end

  // compare only second-stage samples; s1 may be metastable
  assign rise = s_reg.s2 & ~s_reg.prev; // RL14
  assign fall = ~s_reg.s2 & s_reg.prev; // RL14
  assign hit  = (rise & en_rise) | (fall & en_fall); // RL8 RL7 RL9 RL10

  ////////////////////////////////////////////////////////////////////////////
  // raw pin history equals the sync chain only after three edges clear of reset
  AST_RISE_ARMED: assert property (@(posedge clk) disable iff (rst) // RL8
    !($past(rst) || $past(rst, 2) || $past(rst, 3))
    |-> (($past(pins, 2) & ~$past(pins, 3) & en_rise & ~hit) == 8'h00))
    else $error("armed rising edge produced no hit");

  AST_FALL_ARMED: assert property (@(posedge clk) disable iff (rst) // RL7
    !($past(rst) || $past(rst, 2) || $past(rst, 3))
    |-> ((~$past(pins, 2) & $past(pins, 3) & en_fall & ~hit) == 8'h00))
    else $error("armed falling edge produced no hit");

  AST_DISARMED: assert property (@(posedge clk) disable iff (rst) // RL9
    !($past(rst) || $past(rst, 2) || $past(rst, 3))
    |-> ((hit & ~(($past(pins, 2) & ~$past(pins, 3) & en_rise) |
                  (~$past(pins, 2) & $past(pins, 3) & en_fall))) == 8'h00))
    else $error("hit without an enabled edge direction");

  AST_BOTH_DIR: assert property (@(posedge clk) disable iff (rst) // RL10
    !($past(rst) || $past(rst, 2) || $past(rst, 3))
    |-> ((en_rise & en_fall & ($past(pins, 2) ^ $past(pins, 3)) & ~hit) == 8'h00))
    else $error("pin armed both ways missed an edge");

  AST_SYNC_DELAY: assert property (@(posedge clk) disable iff (rst) // RL14
    (hit != 8'h00) |-> ((hit & ~(s_reg.s2 ^ $past(s_reg.s2))) == 8'h00))
    else $error("hit without change between consecutive samples");

endmodule : pecd_edge
`default_nettype wire

// File: logic/pecd_axil.sv
`include "pecd_map.svh"
`default_nettype none
module pecd_axil
  import pecd_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic [15:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [15:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  pecd_if.bus_side         regs
);

  pecd_axil_st_t q;
  pecd_axil_st_t n;
  logic          do_write;

  ////////////////////////////////////////////////////////////////////////////
  assign s_axi_awready = !q.aw_held && !q.bvalid;
  assign s_axi_wready  = !q.w_held && !q.bvalid;
  assign s_axi_arready = !q.rvalid;
  assign s_axi_bvalid  = q.bvalid;
  assign s_axi_bresp   = q.bresp;
  assign s_axi_rvalid  = q.rvalid;
  assign s_axi_rdata   = q.rdata;
  assign s_axi_rresp   = q.rresp;

  // write commits one cycle after both halves are held
  assign do_write      = q.aw_held && q.w_held && !q.bvalid;
  assign regs.wr_en    = do_write && q.wlane0;
  assign regs.wr_idx   = q.aw_idx;
  assign regs.wr_data  = q.wdata;
  assign regs.rd_idx   = s_axi_araddr[13:2];

  always_comb
  begin
    n = q;
    if (s_axi_awvalid && s_axi_awready)
    begin
      n.aw_held = 1'b1;
      n.aw_idx  = s_axi_awaddr[13:2];
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      n.w_held = 1'b1;
      n.wdata  = s_axi_wdata[7:0];
      n.wlane0 = s_axi_wstrb[0];
    end
    if (do_write)
    begin
      n.aw_held = 1'b0;
      n.w_held  = 1'b0;
      n.bvalid  = 1'b1;
      n.bresp   = regs.wr_hit ? `PECD_RESP_OKAY : `PECD_RESP_DECERR;
    end
    else if (q.bvalid && s_axi_bready)
    begin
      n.bvalid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready)
    begin
      n.rvalid = 1'b1;
      n.rdata  = {24'h000000, regs.rd_data};
      n.rresp  = regs.rd_hit ? `PECD_RESP_OKAY : `PECD_RESP_DECERR;
    end
    else if (q.rvalid && s_axi_rready)
    begin
      n.rvalid = 1'b0;
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      q <= '0;
    end
    else
    begin
      q <= n;
    end
  end

endmodule : pecd_axil
`default_nettype wire

// File: logic/pecd_top.sv
// Summary of operation
// RL1: an armed rising edge on a port C pin sets that pin's change flag
// RL2: an armed falling edge on a port C pin sets that pin's change flag
// RL3: a change flag reads zero until an armed edge, or after software zeroes it
// RL4: port E flag and enable registers hold only bit 3; other bits read zero
// RL5: port E pin 3 flag sets on armed rising or falling edges
// RL6: reset-pin or low-voltage setting high disables port E pin 3 detection
// RL7: a falling enable arms falling edges; a hit sets pin flag and summary
// RL8: a rising enable arms rising edges; a hit sets pin flag and summary
// RL9: a cleared enable bit stops that edge direction setting the flag
// RL10: both enables set on a pin detect edges in both directions
// RL11: summary is OR of all flags; interrupt only while change enable set
// RL12: an edge during a flag write leaves that flag set
// RL13: with change interrupt enabled, an armed edge in sleep requests wake
// RL14: pins pass two flops; an edge compares consecutive synchronised samples
// RL15: reset clears every enable bit and every change flag
`include "pecd_map.svh"
`default_nettype none
module pecd_top
  import pecd_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic [15:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [15:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic [7:0]  port_a_pins,
  input  wire logic [7:0]  port_b_pins,
  input  wire logic [7:0]  port_c_pins,
  input  wire logic        port_e_pin3,
  input  wire logic        sleep_mode,
  output logic             change_summary_flag,
  output logic             wake_req,
  output logic             irq
);

  localparam logic [11:0] BASE [4] = '{`PECD_IDX_A_FLAGS, `PECD_IDX_B_FLAGS,
                                       `PECD_IDX_C_FLAGS, `PECD_IDX_E_FLAGS};
  localparam int PORT_C = 2;
  localparam int PORT_E = 3;

  pecd_top_st_t    q;
  pecd_top_st_t    n;
  logic [3:0][7:0] pins;
  logic [3:0][7:0] raw_hit;
  logic [3:0][7:0] hit;
  logic            e_avail;
  logic            c_flag_wr;

  pecd_if regs ();

  ////////////////////////////////////////////////////////////////////////////
  pecd_axil u_axil (
    .clk           (clk),
    .rst           (rst),
    .s_axi_awaddr  (s_axi_awaddr),
    .s_axi_awvalid (s_axi_awvalid),
    .s_axi_awready (s_axi_awready),
    .s_axi_wdata   (s_axi_wdata),
    .s_axi_wstrb   (s_axi_wstrb),
    .s_axi_wvalid  (s_axi_wvalid),
    .s_axi_wready  (s_axi_wready),
    .s_axi_bresp   (s_axi_bresp),
    .s_axi_bvalid  (s_axi_bvalid),
    .s_axi_bready  (s_axi_bready),
    .s_axi_araddr  (s_axi_araddr),
    .s_axi_arvalid (s_axi_arvalid),
    .s_axi_arready (s_axi_arready),
    .s_axi_rdata   (s_axi_rdata),
    .s_axi_rresp   (s_axi_rresp),
    .s_axi_rvalid  (s_axi_rvalid),
    .s_axi_rready  (s_axi_rready),
    .regs          (regs.bus_side)
  );

  ////////////////////////////////////////////////////////////////////////////
  // unused port E pins are tied low so they can never produce an edge
  assign pins[0] = port_a_pins;
  assign pins[1] = port_b_pins;
  assign pins[2] = port_c_pins;
  assign pins[3] = {4'h0, port_e_pin3, 3'h0};

  for (genvar p = 0; p < 4; p++)
  begin : g_port
    pecd_edge u_edge (
      .clk     (clk),
      .rst     (rst),
      .pins    (pins[p]),
      .en_rise (q.rise_en[p]),
      .en_fall (q.fall_en[p]),
      .hit     (raw_hit[p])
    );
  end

  // pin 3 of port E is lost to the reset or programming function
  assign e_avail = !(q.rpe || q.low_voltage_program_setting); // RL6
  assign hit[0]  = raw_hit[0];
  assign hit[1]  = raw_hit[1];
  assign hit[2]  = raw_hit[2]; // RL1 RL2
  assign hit[3]  = raw_hit[3] & `PECD_E_MASK & {8{e_avail}}; // RL4 RL5 RL6

  ////////////////////////////////////////////////////////////////////////////
  always_comb
  begin
    regs.rd_data = 8'h00;
    regs.rd_hit  = 1'b0;
    regs.wr_hit  = 1'b0;
    for (int p = 0; p < 4; p++)
    begin
      if (regs.rd_idx == BASE[p])
      begin
        regs.rd_data = q.flags[p];
        regs.rd_hit  = 1'b1;
      end
      if (regs.rd_idx == BASE[p] + 12'h001)
      begin
        regs.rd_data = q.fall_en[p];
        regs.rd_hit  = 1'b1;
      end
      if (regs.rd_idx == BASE[p] + 12'h002)
      begin
        regs.rd_data = q.rise_en[p];
        regs.rd_hit  = 1'b1;
      end
      if (regs.wr_idx == BASE[p] || regs.wr_idx == BASE[p] + 12'h001 ||
          regs.wr_idx == BASE[p] + 12'h002)
      begin
        regs.wr_hit = 1'b1;
      end
    end
    unique case (regs.rd_idx)
      `PECD_IDX_CTRL:
      begin
        regs.rd_data = {5'h00, q.low_voltage_program_setting, q.rpe, q.cie};
        regs.rd_hit  = 1'b1;
      end
      `PECD_IDX_STATUS:
      begin
        regs.rd_data = {6'h00, e_avail, change_summary_flag};
        regs.rd_hit  = 1'b1;
      end
      `PECD_IDX_INT_STAT:
      begin
        regs.rd_data = {4'h0, q.int_status};
        regs.rd_hit  = 1'b1;
      end
      `PECD_IDX_INT_MASK:
      begin
        regs.rd_data = {4'h0, q.int_mask};
        regs.rd_hit  = 1'b1;
      end
      default:
      begin
      end
    endcase
    if (regs.wr_idx == `PECD_IDX_CTRL || regs.wr_idx == `PECD_IDX_STATUS ||
        regs.wr_idx == `PECD_IDX_INT_STAT || regs.wr_idx == `PECD_IDX_INT_MASK)
    begin
      regs.wr_hit = 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always_comb
  begin
    n = q;
    for (int p = 0; p < 4; p++)
    begin
      if (regs.wr_en && regs.wr_idx == BASE[p])
      begin
        n.flags[p] = regs.wr_data & ((p == PORT_E) ? `PECD_E_MASK : 8'hFF); // RL3 RL4
      end
      if (regs.wr_en && regs.wr_idx == BASE[p] + 12'h001)
      begin
        n.fall_en[p] = regs.wr_data & ((p == PORT_E) ? `PECD_E_MASK : 8'hFF); // RL4
      end
      if (regs.wr_en && regs.wr_idx == BASE[p] + 12'h002)
      begin
        n.rise_en[p] = regs.wr_data & ((p == PORT_E) ? `PECD_E_MASK : 8'hFF); // RL4
      end
    end
    if (regs.wr_en && regs.wr_idx == `PECD_IDX_CTRL)
    begin
      n.cie = regs.wr_data[`PECD_CTRL_CIE];
      n.rpe = regs.wr_data[`PECD_CTRL_RPE];
      n.low_voltage_program_setting = regs.wr_data[`PECD_CTRL_LVP];
    end
    if (regs.wr_en && regs.wr_idx == `PECD_IDX_INT_MASK)
    begin
      n.int_mask = regs.wr_data[3:0];
    end
    if (regs.wr_en && regs.wr_idx == `PECD_IDX_INT_STAT)
    begin
      n.int_status = q.int_status & ~regs.wr_data[3:0];
    end
    // hardware sets are applied last so an edge beats a concurrent write
    for (int p = 0; p < 4; p++)
    begin
      n.flags[p]      = n.flags[p] | hit[p]; // RL1 RL2 RL5 RL12
      n.int_status[p] = n.int_status[p] | (|hit[p]);
    end
    n.irq = q.cie && ((q.int_status & q.int_mask) != 4'h0); // RL11
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      q <= '0; // RL15
    end
    else
    begin
      q <= n;
    end
  end

  assign change_summary_flag = |q.flags; // RL11
  // detection keeps running in sleep; the wake request is the only gated path
  assign wake_req            = sleep_mode && q.cie && change_summary_flag; // RL13
  assign irq                 = q.irq;
  assign c_flag_wr           = regs.wr_en && regs.wr_idx == `PECD_IDX_C_FLAGS;

  ////////////////////////////////////////////////////////////////////////////
  AST_C_FLAG_SET: assert property (@(posedge clk) disable iff (rst) // RL1 RL2
    (hit[PORT_C] != 8'h00) |=> ((q.flags[PORT_C] & $past(hit[PORT_C])) == $past(hit[PORT_C])))
    else $error("port C edge did not set its flag");

  AST_WRITE_ZERO: assert property (@(posedge clk) disable iff (rst) // RL3
    (c_flag_wr && hit[PORT_C] == 8'h00) |=> (q.flags[PORT_C] == $past(regs.wr_data)))
    else $error("port C flag write not stored");

  AST_SET_WINS: assert property (@(posedge clk) disable iff (rst) // RL12
    (c_flag_wr && hit[PORT_C] != 8'h00)
    |=> ((q.flags[PORT_C] & $past(hit[PORT_C])) == $past(hit[PORT_C])))
    else $error("edge lost during flag write");

  AST_E_ONLY_BIT3: assert property (@(posedge clk) disable iff (rst) // RL4
    ((q.flags[PORT_E] | q.rise_en[PORT_E] | q.fall_en[PORT_E]) & ~`PECD_E_MASK) == 8'h00)
    else $error("port E holds a bit other than pin 3");

  AST_E_FLAG_SET: assert property (@(posedge clk) disable iff (rst) // RL5
    (raw_hit[PORT_E][`PECD_E_BIT] && e_avail) |=> q.flags[PORT_E][`PECD_E_BIT])
    else $error("port E pin 3 edge did not set its flag");

  AST_E_UNAVAIL: assert property (@(posedge clk) disable iff (rst) // RL6
    (!e_avail && !(regs.wr_en && regs.wr_idx == `PECD_IDX_E_FLAGS))
    |=> !$rose(q.flags[PORT_E][`PECD_E_BIT]))
    else $error("port E pin 3 flag set while unavailable");

  AST_IRQ_GATED: assert property (@(posedge clk) disable iff (rst) // RL11
    irq |-> ($past(q.cie) && ($past(q.int_status & q.int_mask) != 4'h0)))
    else $error("interrupt raised without change enable");

  AST_WAKE: assert property (@(posedge clk) disable iff (rst) // RL13
    (sleep_mode && q.cie && hit[PORT_C] != 8'h00 &&
     !(regs.wr_en && regs.wr_idx == `PECD_IDX_CTRL)) |=> wake_req || !sleep_mode)
    else $error("armed edge in sleep gave no wake request");

  AST_RESET_CLEAR: assert property (@(posedge clk) // RL15
    $fell(rst) |-> (q.flags == '0 && q.rise_en == '0 && q.fall_en == '0))
    else $error("enables or flags not cleared by reset");

  AST_IRQ_RAISE: assert property (@(posedge clk) disable iff (rst) // RL11
    (q.cie && (q.int_status & q.int_mask) != 4'h0) |=> irq)
    else $error("unmasked change event raised no interrupt");

  AST_IRQ_MASKED: assert property (@(posedge clk) disable iff (rst) // RL11
    (!q.cie || (q.int_status & q.int_mask) == 4'h0) |=> !irq)
    else $error("interrupt raised with every event masked");

  AST_SUMMARY_CAUSE: assert property (@(posedge clk) disable iff (rst) // RL11
    $rose(change_summary_flag) |-> $past(hit != '0 || regs.wr_en))
    else $error("summary rose without an edge or a write");

  AST_C_NO_STRAY: assert property (@(posedge clk) disable iff (rst) // RL9
    !c_flag_wr |=> ((q.flags[PORT_C] & ~$past(q.flags[PORT_C]) & ~$past(hit[PORT_C]))
                    == 8'h00))
    else $error("port C flag set without an enabled edge");

  AST_C_STICKY: assert property (@(posedge clk) disable iff (rst) // RL3
    !c_flag_wr |=> (($past(q.flags[PORT_C]) & ~q.flags[PORT_C]) == 8'h00))
    else $error("port C flag fell without a software write");

  AST_C_EVENT: assert property (@(posedge clk) disable iff (rst) // RL7 RL8
    (hit[PORT_C] != 8'h00) |=> q.int_status[PORT_C])
    else $error("port C edge did not set its event bit");

  AST_E_EVENT: assert property (@(posedge clk) disable iff (rst) // RL5
    (raw_hit[PORT_E][`PECD_E_BIT] && e_avail) |=> q.int_status[PORT_E])
    else $error("port E pin 3 edge did not set its event bit");

endmodule : pecd_top
`default_nettype wire

// File: tb/pecd_pin_drv.sv
`default_nettype none
module pecd_pin_drv
(
  input  wire logic        clk,
  input  wire logic [31:0] want,
  output logic      [7:0]  pa,
  output logic      [7:0]  pb,
  output logic      [7:0]  pc,
  output logic             pe
);
  timeunit 1ns;
  timeprecision 1ns;

  // pins follow the request one clock later, like a remote driver on the board
  initial
  begin
    {pa, pb, pc, pe} = 25'h0;
  end

  always @(posedge clk)
  begin
    pa <= want[7:0];
    pb <= want[15:8];
    pc <= want[23:16];
    pe <= want[27];
  end
endmodule : pecd_pin_drv
`default_nettype wire

// File: tb/tb_top.sv
`include "pecd_map.svh"
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;

  logic        clk, rst, awvalid, wvalid, bready, arvalid, rready, sleep;
  logic        awready, wready, bvalid, arready, rvalid, summ, wake, irq;
  logic [15:0] awaddr, araddr;
  logic [31:0] wdata, rdata, want, rnd, rd;
  logic [3:0]  wstrb, mist, mmask;
  logic [1:0]  bresp, rresp, rsp;
  logic [2:0]  mctrl;
  logic [7:0]  pa, pb, pc, mflg[4], mren[4], mfen[4], mlvl[4];
  logic        pe;
  logic [11:0] fbase[4] = '{`PECD_IDX_A_FLAGS, `PECD_IDX_B_FLAGS, `PECD_IDX_C_FLAGS,
                            `PECD_IDX_E_FLAGS};
  logic [7:0]  pmask[4] = '{8'hFF, 8'hFF, 8'hFF, `PECD_E_MASK};
  int          n_fail, checks;

  pecd_pin_drv partner (.clk(clk), .want(want), .pa(pa), .pb(pb), .pc(pc), .pe(pe));

  pecd_top dut
  (
    .clk(clk), .rst(rst),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .port_a_pins(pa), .port_b_pins(pb), .port_c_pins(pc), .port_e_pin3(pe),
    .sleep_mode(sleep), .change_summary_flag(summ), .wake_req(wake), .irq(irq)
  );

  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic print_verdict();
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : print_verdict

  // each channel is held until its own ready; only the watchdog bounds the wait
  task automatic axw(input logic [11:0] idx, input logic [7:0] d);
    @(posedge clk);
    awaddr  <= {2'b00, idx, 2'b00};
    wdata   <= {24'h0, d};
    wstrb   <= 4'hF;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do
    begin
      @(posedge clk);
      if (awvalid && awready)
        awvalid <= 1'b0;
      if (wvalid && wready)
        wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    rsp = bresp;
    bready <= 1'b0;
  endtask : axw

  task automatic axr(input logic [11:0] idx);
    @(posedge clk);
    araddr  <= {2'b00, idx, 2'b00};
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do
    begin
      @(posedge clk);
      if (arvalid && arready)
        arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rd = rdata;
    rsp = rresp;
    rready <= 1'b0;
  endtask : axr

  task automatic rchk(input logic [11:0] idx, input logic [7:0] exp);
    axr(idx);
    chk(rd, {24'h0, exp});
    chk(rsp, `PECD_RESP_OKAY);
  endtask : rchk

  // new random pin levels; the model applies the armed-edge rules per port
  task automatic step();
    logic [7:0] nl, hit;
    rnd = lfsr(rnd);
    for (int p = 0; p < 4; p++)
    begin
      nl = rnd[8*p +: 8] & pmask[p];
      hit = (nl & ~mlvl[p] & mren[p]) | (~nl & mlvl[p] & mfen[p]);
      if (p == 3 && mctrl[2:1] != 2'b00)
        hit = 8'h00;
      mflg[p] |= hit;
      if (hit != 8'h00)
        mist[p] = 1'b1;
      mlvl[p] = nl;
    end
    want  <= rnd;
    sleep <= rnd[31];
    repeat (6) @(posedge clk);
  endtask : step

  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  initial
  begin
    #(100 * 40000);
    n_fail++;
    print_verdict();
  end

  initial
  begin
    {rst, awvalid, wvalid, bready, arvalid, rready, sleep} = 7'b1000000;
    {awaddr, araddr, wdata, wstrb, want} = '0;
    {n_fail, checks} = '0;
    {mist, mmask, mctrl} = '0;
    rnd = 32'hD55B;
    for (int p = 0; p < 4; p++)
      {mflg[p], mren[p], mfen[p], mlvl[p]} = 32'h0;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    for (int p = 0; p < 4; p++)
      for (int k = 0; k < 3; k++)
        rchk(fbase[p] + 12'(k), 8'h00);
    rchk(`PECD_IDX_CTRL, 8'h00);
    axr(12'h000);
    chk(rd, 32'h0);
    chk(rsp, `PECD_RESP_DECERR);
    axw(12'h000, 8'h5A);
    chk(rsp, `PECD_RESP_DECERR);
    mmask = 4'b1011;
    axw(`PECD_IDX_INT_MASK, {4'h0, mmask});
    for (int i = 0; i < 24; i++)
    begin
      if (i % 6 == 0)
      begin
        for (int p = 0; p < 4; p++)
        begin
          rnd = lfsr(rnd);
          mren[p] = rnd[7:0] & pmask[p];
          mfen[p] = rnd[15:8] & pmask[p];
          axw(fbase[p] + 12'h2, rnd[7:0]);
          axw(fbase[p] + 12'h1, rnd[15:8]);
          rchk(fbase[p] + 12'h2, mren[p]);
          rchk(fbase[p] + 12'h1, mfen[p]);
        end
      end
      // port E pin 3 is taken away by either setting near the end of the run
      mctrl = (i >= 20) ? 3'b101 : (i >= 16) ? 3'b011 : {2'b00, i[0] | i[2]};
      axw(`PECD_IDX_CTRL, {5'h0, mctrl});
      step();
      chk(summ, |{mflg[0], mflg[1], mflg[2], mflg[3]});
      chk(irq, mctrl[0] & |(mist & mmask));
      chk(wake, sleep & mctrl[0] & |{mflg[0], mflg[1], mflg[2], mflg[3]});
      for (int p = 0; p < 4; p++)
        rchk(fbase[p], mflg[p]);
      rchk(`PECD_IDX_INT_STAT, {4'h0, mist});
      rchk(`PECD_IDX_STATUS, {6'h0, (mctrl[2:1] == 2'b00),
                              |{mflg[0], mflg[1], mflg[2], mflg[3]}});
    end
    // an armed port C edge lands in the very cycle that zero is written to its flags
    mren[2] = 8'hFF;
    mfen[2] = 8'hFF;
    axw(`PECD_IDX_C_RISE, 8'hFF);
    axw(`PECD_IDX_C_FALL, 8'hFF);
    want <= want ^ 32'h00FF0000;
    mlvl[2] = ~mlvl[2];
    mflg[2] = 8'hFF;
    mist[2] = 1'b1;
    @(posedge clk);
    axw(`PECD_IDX_C_FLAGS, 8'h00);
    repeat (4) @(posedge clk);
    rchk(`PECD_IDX_C_FLAGS, 8'hFF);
    chk(summ, 1'b1);
    mctrl = 3'b000;
    axw(`PECD_IDX_CTRL, 8'h00);
    repeat (2) @(posedge clk);
    chk(irq, 1'b0);
    chk(summ, |{mflg[0], mflg[1], mflg[2], mflg[3]});
    for (int p = 0; p < 4; p++)
    begin
      axw(fbase[p], 8'h00);
      rchk(fbase[p], 8'h00);
    end
    chk(summ, 1'b0);
    axw(`PECD_IDX_INT_STAT, 8'h0F);
    rchk(`PECD_IDX_INT_STAT, 8'h00);
    print_verdict();
  end
endmodule : tb_top
`default_nettype wire
